// file: rtl/dsr_pkg.sv
// Package: widths, burst layout and carriers for the DDR burst SRAM port
package dsr_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 36;
  localparam int BURST  = 4;
  localparam int BEAT_W = 2;
  localparam int IDX_W  = ADDR_W + BEAT_W;
  localparam int DEPTH  = 1 << IDX_W;

  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_ONE   = 2'h1;
  localparam logic [BEAT_W-1:0] BEAT_LAST  = 2'h3;

  typedef logic [DATA_W-1:0] dsr_word_t;

  typedef struct packed {
    logic [ADDR_W-1:0]        addr;
    dsr_word_t [BURST-1:0]    data;
  } dsr_wcmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } dsr_rcmd_t;

  typedef struct packed {
    dsr_word_t [BURST-1:0] data;
  } dsr_rsp_t;

  // One link cycle of data: word on the positive edge, word on the negative edge
  typedef struct packed {
    dsr_word_t fall;
    dsr_word_t rise;
  } dsr_pair_t;
endpackage

// file: rtl/dsr_sync.sv
// Two-flop level synchroniser
module dsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dsr_sync_t;

  dsr_sync_t s;
  dsr_sync_t next_s;

  always_comb begin
    next_s.meta   = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk) begin
    s <= next_s;
  end

  assign q = s.stable;
endmodule

// file: rtl/dsr_afifo.sv
// Two-entry dual-clock buffer with gray pointers
module dsr_afifo #(
  parameter int W = 8
) (
  input  wire logic         wclk,
  input  wire logic         wrst_n,
  input  wire logic         w_valid,
  input  wire logic [W-1:0] w_data,
  output logic              w_ready,
  input  wire logic         rclk,
  input  wire logic         rrst_n,
  output logic              r_valid,
  output logic      [W-1:0] r_data,
  input  wire logic         r_ready
);
  typedef struct packed {
    logic [1:0] bin;
    logic [1:0] gray;
  } dsr_fptr_t;

  localparam dsr_fptr_t PTR_RST = '{bin: 2'h0, gray: 2'h0};

  dsr_fptr_t  ws;
  dsr_fptr_t  next_ws;
  dsr_fptr_t  rs;
  dsr_fptr_t  next_rs;
  logic [W-1:0] mem [2];
  logic [1:0] rgray_w;
  logic [1:0] wgray_r;

  function automatic dsr_fptr_t bump(input dsr_fptr_t p);
    logic [1:0] b;
    b = p.bin + 2'h1;
    return '{bin: b, gray: {b[1], b[1] ^ b[0]}};
  endfunction

  dsr_sync #(.W(2)) u_rsync (.clk(wclk), .d(rs.gray), .q(rgray_w));
  dsr_sync #(.W(2)) u_wsync (.clk(rclk), .d(ws.gray), .q(wgray_r));

  // Full when the write pointer is a whole lap ahead
  assign w_ready = (ws.gray != ~rgray_w);
  assign r_valid = (rs.gray != wgray_r);
  assign r_data  = mem[rs.bin[0]];

  always_comb begin
    next_ws = ws;
    if (w_valid && w_ready) begin
      next_ws = bump(ws);
    end
  end

  always_comb begin
    next_rs = rs;
    if (r_valid && r_ready) begin
      next_rs = bump(rs);
    end
  end

  always_ff @(posedge wclk) begin
    if (!wrst_n) begin
      ws <= PTR_RST;
    end else begin
      ws <= next_ws;
    end
  end

  always_ff @(posedge wclk) begin
    if (w_valid && w_ready) begin
      mem[ws.bin[0]] <= w_data;
    end
  end

  always_ff @(posedge rclk) begin
    if (!rrst_n) begin
      rs <= PTR_RST;
    end else begin
      rs <= next_rs;
    end
  end
endmodule

// file: rtl/dsr_sram.sv
// DDR burst SRAM core: shared address capture, read and write ports
module dsr_sram (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      link_clk,
  input  wire logic [dsr_pkg::ADDR_W-1:0] address,
  input  wire logic                      read_port_select_n,
  input  wire logic                      write_port_select_n,
  input  wire dsr_pkg::dsr_pair_t        write_data_in,
  output dsr_pkg::dsr_pair_t             read_data_out,
  output logic                           read_data_oe,
  output logic                           req_ready
);
  typedef enum logic [1:0] {
    W_IDLE = 2'h1,
    W_ADDR = 2'h2
  } dsr_wst_t;

  typedef enum logic [1:0] {
    O_IDLE = 2'h1,
    O_TAIL = 2'h2
  } dsr_ost_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_WR   = 4'h2,
    C_RD   = 4'h4,
    C_RSP  = 4'h8
  } dsr_cst_t;

  typedef struct packed {
    dsr_wst_t           wst;
    dsr_pkg::dsr_pair_t wfirst;
    dsr_ost_t           ost;
    dsr_pkg::dsr_pair_t q;
    dsr_pkg::dsr_pair_t hold;
    logic               oe;
    logic               ready;
  } dsr_link_t;

  typedef struct packed {
    dsr_cst_t                                cst;
    logic [dsr_pkg::BEAT_W-1:0]              beat;
    logic [dsr_pkg::ADDR_W-1:0]              addr;
    dsr_pkg::dsr_word_t [dsr_pkg::BURST-1:0] wdata;
    dsr_pkg::dsr_word_t [dsr_pkg::BURST-1:0] rdata;
  } dsr_core_t;

  localparam dsr_link_t LINK_RST = '{
    wst: W_IDLE, wfirst: '0, ost: O_IDLE, q: '0, hold: '0, oe: 1'b0, ready: 1'b0
  };

  localparam dsr_core_t CORE_RST = '{
    cst: C_IDLE, beat: dsr_pkg::BEAT_FIRST, addr: '0, wdata: '0, rdata: '0
  };

  dsr_link_t l;
  dsr_link_t next_l;
  dsr_core_t c;
  dsr_core_t next_c;
  logic      link_rst_n;

  // Link-side handshakes
  dsr_pkg::dsr_wcmd_t wcmd_in;
  dsr_pkg::dsr_rcmd_t rcmd_in;
  logic               wf_push;
  logic               wf_ready;
  logic               rf_push;
  logic               rf_ready;
  dsr_pkg::dsr_rsp_t  rsp_out;
  logic               rsp_valid;
  logic               rsp_pop;

  // Core-side handshakes
  dsr_pkg::dsr_wcmd_t wcmd_out;
  dsr_pkg::dsr_rcmd_t rcmd_out;
  logic               wf_valid;
  logic               wf_pop;
  logic               rf_valid;
  logic               rf_pop;
  dsr_pkg::dsr_rsp_t  rsp_in;
  logic               rsp_push;
  logic               rsp_ready;

  // Storage: one array indexed by address, with the burst beat in the low index bits
  dsr_pkg::dsr_word_t               mem [dsr_pkg::DEPTH];
  logic [dsr_pkg::IDX_W-1:0]        mem_idx;
  logic                             mem_we;

  dsr_sync #(.W(1)) u_rst_sync (
    .clk (link_clk),
    .d   (rst_n),
    .q   (link_rst_n)
  );

  dsr_afifo #(.W($bits(dsr_pkg::dsr_wcmd_t))) u_wr_fifo (
    .wclk    (link_clk),
    .wrst_n  (link_rst_n),
    .w_valid (wf_push),
    .w_data  (wcmd_in),
    .w_ready (wf_ready),
    .rclk    (mclk),
    .rrst_n  (rst_n),
    .r_valid (wf_valid),
    .r_data  (wcmd_out),
    .r_ready (wf_pop)
  );

  dsr_afifo #(.W($bits(dsr_pkg::dsr_rcmd_t))) u_rd_fifo (
    .wclk    (link_clk),
    .wrst_n  (link_rst_n),
    .w_valid (rf_push),
    .w_data  (rcmd_in),
    .w_ready (rf_ready),
    .rclk    (mclk),
    .rrst_n  (rst_n),
    .r_valid (rf_valid),
    .r_data  (rcmd_out),
    .r_ready (rf_pop)
  );

  dsr_afifo #(.W($bits(dsr_pkg::dsr_rsp_t))) u_rsp_fifo (
    .wclk    (mclk),
    .wrst_n  (rst_n),
    .w_valid (rsp_push),
    .w_data  (rsp_in),
    .w_ready (rsp_ready),
    .rclk    (link_clk),
    .rrst_n  (link_rst_n),
    .r_valid (rsp_valid),
    .r_data  (rsp_out),
    .r_ready (rsp_pop)
  );

  // Link domain: capture on the input clock, drive read data out
  always_comb begin
    next_l       = l;
    wf_push      = 1'b0;
    rf_push      = 1'b0;
    rsp_pop      = 1'b0;
    wcmd_in.addr = address;
    wcmd_in.data = {write_data_in.fall, write_data_in.rise,
                    l.wfirst.fall, l.wfirst.rise};
    rcmd_in.addr = address;

    // Write: first data pair with the select, address and second pair next edge
    case (l.wst)
      W_IDLE: begin
        if (!write_port_select_n) begin
          next_l.wfirst = write_data_in;
          next_l.wst    = W_ADDR;
        end
      end
      W_ADDR: begin
        wf_push    = wf_ready;
        next_l.wst = W_IDLE;
      end
      default: begin
        next_l.wst = W_IDLE;
      end
    endcase

    // Read: address only taken while the read port is selected
    if (!read_port_select_n) begin
      rf_push = rf_ready;
    end

    // Output: two beats per burst, release one edge after the last
    case (l.ost)
      O_IDLE: begin
        if (rsp_valid) begin
          rsp_pop        = 1'b1;
          next_l.q.rise  = rsp_out.data[0];
          next_l.q.fall  = rsp_out.data[1];
          next_l.hold    = {rsp_out.data[3], rsp_out.data[2]};
          next_l.oe      = 1'b1;
          next_l.ost     = O_TAIL;
        end else begin
          next_l.oe = 1'b0;
          next_l.q  = '0;
        end
      end
      O_TAIL: begin
        next_l.q   = l.hold;
        next_l.ost = O_IDLE;
      end
      default: begin
        next_l.ost = O_IDLE;
        next_l.oe  = 1'b0;
      end
    endcase

    next_l.ready = wf_ready && rf_ready;
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      l <= LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  // Core domain: writes before reads keep the newest data visible
  always_comb begin
    next_c   = c;
    wf_pop   = 1'b0;
    rf_pop   = 1'b0;
    rsp_push = 1'b0;
    rsp_in   = c.rdata;
    mem_we   = 1'b0;
    mem_idx  = {c.addr, c.beat};

    case (c.cst)
      C_IDLE: begin
        next_c.beat = dsr_pkg::BEAT_FIRST;
        if (wf_valid) begin
          wf_pop       = 1'b1;
          next_c.addr  = wcmd_out.addr;
          next_c.wdata = wcmd_out.data;
          next_c.cst   = C_WR;
        end else if (rf_valid) begin
          rf_pop      = 1'b1;
          next_c.addr = rcmd_out.addr;
          next_c.cst  = C_RD;
        end
      end
      C_WR: begin
        mem_we      = 1'b1;
        next_c.beat = c.beat + dsr_pkg::BEAT_ONE;
        if (c.beat == dsr_pkg::BEAT_LAST) begin
          next_c.cst = C_IDLE;
        end
      end
      C_RD: begin
        next_c.rdata[c.beat] = mem[mem_idx];
        next_c.beat          = c.beat + dsr_pkg::BEAT_ONE;
        if (c.beat == dsr_pkg::BEAT_LAST) begin
          next_c.cst = C_RSP;
        end
      end
      C_RSP: begin
        rsp_push = 1'b1;
        if (rsp_ready) begin
          next_c.cst = C_IDLE;
        end
      end
      default: begin
        next_c.cst = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      c <= CORE_RST;
    end else begin
      c <= next_c;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_idx] <= c.wdata[c.beat];
    end
  end

  assign read_data_out = l.q;
  assign read_data_oe  = l.oe;
  assign req_ready     = l.ready;
endmodule

// file: bench/dsr_sram_props.sv
// Read-port timing assertions for the DDR burst SRAM
module dsr_sram_props (
  input wire logic               link_clk,
  input wire logic               rst_n,
  input wire logic               read_port_select_n,
  input wire logic               write_port_select_n,
  input wire dsr_pkg::dsr_pair_t read_data_out,
  input wire logic               read_data_oe
);
  logic [7:0] idle;
  logic [7:0] run;
  // Link cycles since the last read select, and length of the current output run
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      idle <= 8'hFF;
      run  <= 8'h00;
    end else begin
      idle <= !read_port_select_n ? 8'h00 : (idle == 8'hFF ? idle : idle + 8'h01);
      run  <= read_data_oe ? run + 8'h01 : 8'h00;
    end
  end
  default clocking @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  chk_rd_starts: assert property (!read_port_select_n |-> ##[1:12] read_data_oe)
    else $error("read select gave no output");
  chk_idle_lat: assert property ((!read_port_select_n && idle > 8'h14) |=>
    !read_data_oe [*2] ##[1:8] read_data_oe) else $error("read latency out of range");
  chk_oe_source: assert property ($rose(read_data_oe) |-> idle < 8'h0C)
    else $error("output without a read select");
  chk_oe_release: assert property (idle > 8'h10 |-> !read_data_oe)
    else $error("drivers not released after reads");
  chk_tristate_zero: assert property (!read_data_oe |-> read_data_out == '0)
    else $error("data driven while released");
  chk_two_beats: assert property ($rose(read_data_oe) |=> read_data_oe)
    else $error("burst shorter than two beats");
  chk_even_beats: assert property ($fell(read_data_oe) |-> !run[0])
    else $error("output run not whole bursts");
  chk_write_quiet: assert property ((!write_port_select_n && idle > 8'h14) |=>
    !read_data_oe [*4]) else $error("write alone drove read data");
  cover property ($rose(read_data_oe));
  cover property (read_data_oe [*4]);
  cover property (!read_port_select_n && !write_port_select_n);
endmodule

bind dsr_sram dsr_sram_props u_props (
  .link_clk(link_clk), .rst_n(rst_n), .read_port_select_n(read_port_select_n),
  .write_port_select_n(write_port_select_n), .read_data_out(read_data_out), .read_data_oe(read_data_oe));

// file: bench/dsr_ctl_model.sv
// Memory-controller model driving address, port selects and write data
module dsr_ctl_model (
  input  wire logic                  link_clk,
  output logic [dsr_pkg::ADDR_W-1:0] address,
  output logic                       read_port_select_n,
  output logic                       write_port_select_n,
  output dsr_pkg::dsr_pair_t         wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    read_port_select_n = 1'b1;
    write_port_select_n = 1'b1;
    address = '0;
    wdata = '0;
  end
  // Unused lines get fresh noise every cycle
  task automatic drive(input logic rs, input logic ws, input bit ua, input logic [17:0] ad,
                       input bit ud, input dsr_pkg::dsr_pair_t pd);
    logic [95:0] r;
    @(negedge link_clk);
    r = {$urandom, $urandom, $urandom};
    read_port_select_n <= rs;
    write_port_select_n <= ws;
    address <= ua ? ad : r[95:78];
    wdata <= ud ? pd : r[71:0];
  endtask
  task automatic cyc(input bit rd, input bit wr, input logic [17:0] ra, input logic [17:0] wa,
                     input dsr_pkg::dsr_word_t d [4]);
    drive(!rd, !wr, rd, ra, wr, {d[1], d[0]});
    drive(1'b1, 1'b1, wr, wa, wr, {d[3], d[2]});
  endtask
  task automatic idle(input int n);
    repeat (n) drive(1'b1, 1'b1, 1'b0, '0, 1'b0, '0);
  endtask
endmodule

// file: bench/ddr_sram_read_port_address_clocking_tb.sv
// Self-checking bench for the DDR burst SRAM read port
module ddr_sram_read_port_address_clocking_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       mclk;
  logic                       link_clk;
  logic                       rst_n;
  logic                       read_port_select_n;
  logic                       write_port_select_n;
  logic                       read_data_oe;
  logic                       req_ready;
  logic [dsr_pkg::ADDR_W-1:0] address;
  dsr_pkg::dsr_pair_t         wdata;
  dsr_pkg::dsr_pair_t         read_data_out;
  dsr_pkg::dsr_word_t         mem [int];
  dsr_pkg::dsr_word_t         xq [$];
  int                         error_cnt = 0;
  int                         total_checks = 0;

  dsr_sram DUT (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk), .address(address),
    .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
    .write_data_in(wdata), .read_data_out(read_data_out), .read_data_oe(read_data_oe),
    .req_ready(req_ready));
  dsr_ctl_model CTL (.link_clk(link_clk), .address(address), .read_port_select_n(read_port_select_n),
    .write_port_select_n(write_port_select_n), .wdata(wdata));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task automatic chk(input dsr_pkg::dsr_word_t got, input dsr_pkg::dsr_word_t exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // One access pair; the model is updated when the request is issued
  task automatic acc(input bit rd, input bit wr, input int ra, input int wa);
    dsr_pkg::dsr_word_t d [4];
    for (int k = 0; k < 4; k++) begin
      d[k] = 36'({$urandom, $urandom});
      if (wr) mem[wa * 4 + k] = d[k];
      if (rd) xq.push_back(mem[ra * 4 + k]);
    end
    CTL.cyc(rd, wr, 18'(ra), 18'(wa), d);
  endtask

  function automatic dsr_pkg::dsr_word_t pop();
    return xq.size() ? xq.pop_front() : 'x;
  endfunction

  // Each output beat: rise lane then fall lane, in burst order
  always @(negedge link_clk) begin
    if (read_data_oe === 1'b1) begin
      chk(read_data_out.rise, pop());
      chk(read_data_out.fall, pop());
    end
  end

  initial begin
    void'($urandom(32'h1FDB310C));
    rst_n = 1'b0;
    // Longer than twelve cycles: the link side needs four of its own edges
    repeat (14) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 40 && req_ready !== 1'b1; i++) @(negedge link_clk);
    chk(36'(req_ready), 36'h1);
    for (int i = 0; i < 6; i++) acc(1'b0, 1'b1, 0, i == 5 ? 18'h3FFFF : i);
    CTL.idle(30);
    // Spacing keeps the core, which serves writes first, ahead of the two-entry buffers
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 1'b1, i == 5 ? 18'h3FFFF : i, 8'h40 + i);
      CTL.idle(4);
    end
    CTL.idle(30);
    for (int i = 0; i < 6; i++) acc(1'b1, 1'b0, 8'h40 + i, 0);
    CTL.idle(30);
    chk(36'(xq.size()), 36'h0);
    results();
  end

  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule
